// ===== src/uvt_pkg.sv
// uvt_pkg: shared constants and carriers for the unequipped vc-3 path termination
// assumes a byte-serial vc-3 stream of 9 rows by 85 columns with a frame-start pulse
`default_nettype none
package uvt_pkg;
   // =====================================================================
   // frame geometry
   localparam int unsigned  COLS          = 85;
   localparam int unsigned  ROWS          = 9;
   localparam int unsigned  FRAME_BYTES   = COLS * ROWS;
   localparam int unsigned  BYTE_CNT_W    = 10;
   // path overhead rows in column 0
   localparam logic [3:0]   ROW_J1        = 4'h0;
   localparam logic [3:0]   ROW_B3        = 4'h1;
   localparam logic [3:0]   ROW_C2        = 4'h2;
   localparam logic [3:0]   ROW_G1        = 4'h3;
   localparam logic [3:0]   ROW_N1        = 4'h7;
   // =====================================================================
   // fixed codes
   localparam logic [7:0]   C2_UNEQ       = 8'h00;
   localparam logic [7:0]   N1_UNEQ       = 8'h00;
   localparam logic [1:0]   G1_ERDI_IDLE  = 2'h0;
   localparam logic         G1_SPARE      = 1'b0;
   localparam logic [7:0]   FILL_BYTE     = 8'h00;
   localparam logic [3:0]   REI_MAX       = 4'h8;
   // g1 bit 1 is the msb: bits 1-4 are [7:4], bit 5 is [3], bits 6-7 are [2:1]
   localparam int unsigned  G1_REI_LSB    = 4;
   localparam int unsigned  G1_RDI_POS    = 3;
   localparam int unsigned  G1_ERDI_LSB   = 1;
   localparam int unsigned  G1_SPARE_POS  = 0;
   // =====================================================================
   // timing: insertion deadline of remote indications
   localparam int unsigned  INSERT_MAX_US = 1000;
   localparam int unsigned  CLK_MHZ       = 50;
   localparam int unsigned  INSERT_MAX_CYC = INSERT_MAX_US * CLK_MHZ;
   localparam int unsigned  SYNC_STAGES   = 3;
   // =====================================================================
   // carriers
   typedef struct packed {
      logic [7:0] data;
      logic       fs;
   } uvt_byte_s;

   typedef struct packed {
      logic       rdi;
      logic [3:0] rei;
   } uvt_remote_s;
endpackage
`default_nettype wire

// ===== src/uvt_source.sv
// uvt_source: link-clock vc-3 generator with path overhead insertion
// assumes remote indications arrive already synchronised to the link clock
`default_nettype none
module uvt_source (
   // link clock
   input  wire logic                i_lclk,
   input  wire logic                i_lrst_n,
   // provisioning and remote status
   input  wire logic [7:0]          i_trace_byte,
   input  wire uvt_pkg::uvt_remote_s i_remote,
   // timing in
   input  wire logic                i_fs,
   // stream out
   output uvt_pkg::uvt_byte_s       o_tx
);
   // =====================================================================
   // position counter
   logic [9:0] pos_r;
   logic [9:0] pos_nxt;
   logic [7:0] bip_r;
   logic [7:0] bip_nxt;
   logic [7:0] b3_r;
   logic [7:0] byte_nxt;
   logic [3:0] row;
   logic       col0;

   always_comb begin
      pos_nxt = (i_fs || pos_r == 10'(uvt_pkg::FRAME_BYTES - 1)) ? 10'h000 : pos_r + 10'h001;
   end

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         pos_r <= 10'h000;
      end else begin
         pos_r <= pos_nxt;
      end
   end

   assign row  = 4'(pos_nxt / 10'(uvt_pkg::COLS));
   assign col0 = (pos_nxt % 10'(uvt_pkg::COLS)) == 10'h000;

   // =====================================================================
   // byte mux
   always_comb begin
      byte_nxt = uvt_pkg::FILL_BYTE; // R9
      if (col0) begin
         if (row == uvt_pkg::ROW_J1) begin
            byte_nxt = i_trace_byte; // R1
         end else if (row == uvt_pkg::ROW_B3) begin
            byte_nxt = b3_r; // R2
         end else if (row == uvt_pkg::ROW_C2) begin
            byte_nxt = uvt_pkg::C2_UNEQ; // R3
         end else if (row == uvt_pkg::ROW_G1) begin
            byte_nxt = {(i_remote.rei > uvt_pkg::REI_MAX) ? uvt_pkg::REI_MAX : i_remote.rei, // R4
                        i_remote.rdi, // R5
                        uvt_pkg::G1_ERDI_IDLE, // R6
                        uvt_pkg::G1_SPARE}; // R7
         end else if (row == uvt_pkg::ROW_N1) begin
            byte_nxt = uvt_pkg::N1_UNEQ; // R8
         end
      end
   end

   // =====================================================================
   // bip-8 over the whole generated frame, latched at wrap
   always_comb begin
      bip_nxt = (pos_nxt == 10'h000) ? byte_nxt : (bip_r ^ byte_nxt);
   end

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         bip_r <= 8'h00;
         b3_r  <= 8'h00;
      end else begin
         bip_r <= bip_nxt;
         if (pos_nxt == 10'h000) begin
            b3_r <= bip_r; // R2
         end
      end
   end

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         o_tx <= '0;
      end else begin
         o_tx.data <= byte_nxt;
         o_tx.fs   <= (pos_nxt == 10'h000);
      end
   end
   // no defect detection or counting lives here R10
endmodule
`default_nettype wire

// ===== src/uvt_term.sv
// uvt_term: supervisory-unequipped vc-3 path trail termination, source and sink
// assumes the vc-3 stream runs on i_lclk with a one-cycle frame-start pulse;
// management signals live on i_clk
//
// Behaviour
// R1: j1 carries provisioned transmitted trace
// R2: b3 is even bip-8 of previous frame
// R3: c2 transmitted as all zeros
// R4: g1 bits 1-4 carry remote error count
// R5: g1 bit 5 follows remote defect
// R6: g1 bits 6-7 sent as 00
// R7: g1 bit 8 value is free
// R8: n1 transmitted as all zeros
// R9: other bytes generated, content arbitrary
// R10: source detects and counts nothing
// R11: j1 extracted as accepted trace
// R12: bip-8 mismatch flags near-end errored block
// R13: g1 bits 1-4 decoded to far-end block
// R14: g1 bit 5 is remote receiver status
// R15: g1 bits 6-8 ignored on receive
// R16: c2 extracted for unequipped defect
// R17: fail actions from ssf or mismatch only
// R18: remote defect report gated by monitoring
// R19: remote outputs updated once per frame
`default_nettype none
module uvt_term (
   // system clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   // link clock and reset
   input  wire logic                i_lclk,
   input  wire logic                i_lrst_n,
   // receive stream
   input  wire uvt_pkg::uvt_byte_s  i_rx,
   input  wire logic                i_server_signal_fail_in,
   // transmit stream
   input  wire logic                i_tx_fs,
   output uvt_pkg::uvt_byte_s       o_tx,
   // management
   input  wire logic [7:0]          i_transmitted_trace_id,
   input  wire logic [7:0]          i_expected_trace_id,
   input  wire logic                i_trace_check_enable,
   input  wire logic                i_monitoring_on,
   input  wire logic                i_remote_defect_report_enable,
   output logic [7:0]               o_accepted_trace_id,
   output logic                     o_near_end_errored_block,
   output logic                     o_far_end_errored_block,
   output logic                     o_remote_defect_cause,
   output logic                     o_unequipped_defect,
   output logic                     o_trace_mismatch_defect,
   output logic                     o_trail_signal_fail_action,
   output logic                     o_remote_defect_action
);
   // =====================================================================
   // crossings into the link domain (ssf and tim: three stages, agreement of last two)
   logic [2:0]  ssf_l_r;
   logic [2:0]  tim_l_r;
   logic        ssf_l;
   logic        tim_l;
   logic [7:0]  tx_trace_l_r;
   logic [7:0]  tx_trace_m_r;

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         ssf_l_r <= 3'h0;
         tim_l_r <= 3'h0;
         ssf_l   <= 1'b0;
         tim_l   <= 1'b0;
      end else begin
         ssf_l_r <= {ssf_l_r[1:0], i_server_signal_fail_in};
         tim_l_r <= {tim_l_r[1:0], o_trace_mismatch_defect};
         if (ssf_l_r[1] == ssf_l_r[2]) begin
            ssf_l <= ssf_l_r[2];
         end
         if (tim_l_r[1] == tim_l_r[2]) begin
            tim_l <= tim_l_r[2];
         end
      end
   end

   // trace is static provisioning; two stages settle it before use
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         tx_trace_m_r <= 8'h00;
         tx_trace_l_r <= 8'h00;
      end else begin
         tx_trace_m_r <= i_transmitted_trace_id;
         tx_trace_l_r <= tx_trace_m_r;
      end
   end

   // =====================================================================
   // sink position tracking on the received stream
   logic [9:0]  rpos_r;
   logic [9:0]  rpos;
   logic [3:0]  rrow;
   logic        rcol0;
   logic        rstart;

   assign rpos   = i_rx.fs ? 10'h000 : rpos_r;
   assign rrow   = 4'(rpos / 10'(uvt_pkg::COLS));
   assign rcol0  = (rpos % 10'(uvt_pkg::COLS)) == 10'h000;
   assign rstart = (rpos == 10'h000);

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         rpos_r <= 10'h000;
      end else if (rpos == 10'(uvt_pkg::FRAME_BYTES - 1)) begin
         rpos_r <= 10'h000;
      end else begin
         rpos_r <= rpos + 10'h001;
      end
   end

   // =====================================================================
   // sink overhead extraction
   logic [7:0]  rbip_r;
   logic [7:0]  prev_bip_r;
   logic        prev_valid_r;
   logic        seen_fs_r;
   logic [7:0]  j1_l_r;
   logic [7:0]  c2_l_r;
   logic        neb_tgl_r;
   logic        feb_tgl_r;
   logic        rdi_l_r;
   uvt_pkg::uvt_remote_s remote_l_r;
   logic [3:0]  rei_acc_r;

   function automatic logic rei_blocks(input logic [3:0] code);
      rei_blocks = (code != 4'h0) && (code <= uvt_pkg::REI_MAX);
   endfunction

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         rbip_r       <= 8'h00;
         prev_bip_r   <= 8'h00;
         prev_valid_r <= 1'b0;
         seen_fs_r    <= 1'b0;
      end else begin
         rbip_r <= rstart ? i_rx.data : (rbip_r ^ i_rx.data);
         if (i_rx.fs) begin
            seen_fs_r <= 1'b1;
         end
         // a start before the first fs is only the idle counter, so its parity is not trusted
         if (rstart) begin
            prev_bip_r   <= rbip_r;
            prev_valid_r <= seen_fs_r;
         end
      end
   end

   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         j1_l_r    <= 8'h00;
         c2_l_r    <= 8'h00;
         neb_tgl_r <= 1'b0;
         feb_tgl_r <= 1'b0;
         rdi_l_r   <= 1'b0;
      end else if (rcol0) begin
         if (rrow == uvt_pkg::ROW_J1) begin
            j1_l_r <= i_rx.data; // R11
         end else if (rrow == uvt_pkg::ROW_B3) begin
            if (prev_valid_r && (i_rx.data != prev_bip_r)) begin
               neb_tgl_r <= ~neb_tgl_r; // R12
            end
         end else if (rrow == uvt_pkg::ROW_C2) begin
            c2_l_r <= i_rx.data; // R16
         end else if (rrow == uvt_pkg::ROW_G1) begin
            if (rei_blocks(i_rx.data[uvt_pkg::G1_REI_LSB +: 4])) begin
               feb_tgl_r <= ~feb_tgl_r; // R13
            end
            rdi_l_r <= i_rx.data[uvt_pkg::G1_RDI_POS]; // R14
            // bits 6-8 are not looked at R15
         end
      end
   end

   // near-end errored blocks of the frame, reported back once per frame
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         rei_acc_r  <= 4'h0;
         remote_l_r <= '0;
      end else if (rstart) begin
         rei_acc_r      <= 4'h0;
         remote_l_r.rei <= rei_acc_r; // R19
         remote_l_r.rdi <= ssf_l || tim_l; // R17 R19
      end else if (rcol0 && rrow == uvt_pkg::ROW_B3 && prev_valid_r && (i_rx.data != prev_bip_r)) begin
         rei_acc_r <= 4'h1; // one block per frame at most
      end
   end

   // =====================================================================
   // source on the link clock
   uvt_source u_source (
      .i_lclk       (i_lclk),
      .i_lrst_n     (i_lrst_n),
      .i_trace_byte (tx_trace_l_r),
      .i_remote     (remote_l_r),
      .i_fs         (i_tx_fs),
      .o_tx         (o_tx)
   );

   // =====================================================================
   // crossings into the system domain
   logic [2:0]  neb_s_r;
   logic [2:0]  feb_s_r;
   logic [2:0]  rdi_s_r;
   logic        rdi_s;
   logic [7:0]  j1_m_r;
   logic [7:0]  c2_m_r;
   logic [7:0]  j1_s_r;
   logic [7:0]  c2_s_r;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         neb_s_r <= 3'h0;
         feb_s_r <= 3'h0;
         rdi_s_r <= 3'h0;
         rdi_s   <= 1'b0;
      end else begin
         neb_s_r <= {neb_s_r[1:0], neb_tgl_r};
         feb_s_r <= {feb_s_r[1:0], feb_tgl_r};
         rdi_s_r <= {rdi_s_r[1:0], rdi_l_r};
         if (rdi_s_r[1] == rdi_s_r[2]) begin
            rdi_s <= rdi_s_r[2];
         end
      end
   end

   // overhead bytes change at most once a frame (125 us), far slower than the crossing
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         j1_m_r <= 8'h00;
         c2_m_r <= 8'h00;
         j1_s_r <= 8'h00;
         c2_s_r <= 8'h00;
      end else begin
         j1_m_r <= j1_l_r;
         c2_m_r <= c2_l_r;
         j1_s_r <= j1_m_r;
         c2_s_r <= c2_m_r;
      end
   end

   // =====================================================================
   // management outputs
   logic        tim;

   assign tim = i_trace_check_enable && (j1_s_r != i_expected_trace_id);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_accepted_trace_id        <= 8'h00;
         o_near_end_errored_block   <= 1'b0;
         o_far_end_errored_block    <= 1'b0;
         o_unequipped_defect        <= 1'b0;
         o_trace_mismatch_defect    <= 1'b0;
         o_trail_signal_fail_action <= 1'b0;
         o_remote_defect_action     <= 1'b0;
         o_remote_defect_cause      <= 1'b0;
      end else begin
         o_accepted_trace_id        <= j1_s_r; // R11
         o_near_end_errored_block   <= neb_s_r[2] ^ neb_s_r[1]; // R12
         o_far_end_errored_block    <= feb_s_r[2] ^ feb_s_r[1]; // R13
         o_unequipped_defect        <= (c2_s_r == uvt_pkg::C2_UNEQ); // R16
         o_trace_mismatch_defect    <= tim;
         o_trail_signal_fail_action <= i_server_signal_fail_in || tim; // R17
         o_remote_defect_action     <= i_server_signal_fail_in || tim; // R17
         o_remote_defect_cause      <= i_monitoring_on && !tim && rdi_s
                                       && i_remote_defect_report_enable; // R18
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench for uvt_term against a far-side stream model
// assumes uvt_pkg, uvt_far_end and the bound checker are compiled first
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0]  kind;
      logic [13:0] val;
   } uvt_note_s;
   // ctl: {j1, c2 ff, g1 rdi, ssf, check, mon, report}
   localparam logic [13:0] STEPS [10] = '{14'h1687, 14'h1697, 14'h1696, 14'h1697, 14'h1695,
                                         14'h1697, 14'h2957, 14'h2953, 14'h295b, 14'h2973};
   logic               i_clk = 1'b0;
   logic               i_lclk = 1'b0;
   logic               i_rst_n = 1'b0;
   logic               i_lrst_n = 1'b0;
   logic [13:0]        ctl_r = 14'h1687;
   logic [7:0]         g1_r = 8'h00;
   logic [7:0]         fill_r = 8'h00;
   logic [7:0]         tx_id = 8'h3c;
   logic               bad_r = 1'b0;
   logic               tx_rdi = 1'b0;
   logic [9:0]         tcnt = 10'h000;
   logic [31:0]        rnd = 32'h0000a13e;
   logic [12:0]        prev = 13'h0000;
   int                 bad_count = 0;
   int                 comparisons = 0;
   uvt_note_s          notes [$];
   uvt_pkg::uvt_byte_s rx;
   uvt_pkg::uvt_byte_s tx;
   logic [7:0]         acc;
   logic               neb, feb, rdc, uneq, tim, tsf, rda;
   wire logic [12:0]   vec = {acc, uneq, tim, tsf, rda, rdc};
   initial forever #10 i_clk = ~i_clk;
   initial begin
      #7;
      forever #15 i_lclk = ~i_lclk;
   end
   uvt_far_end uvt_far_end_i (.i_lclk, .i_lrst_n, .i_bad(bad_r), .o_rx(rx),
      .i_cfg({ctl_r[13:6], ctl_r[5] ? 8'hff : 8'h00, g1_r | {4'h0, ctl_r[4], 3'h0}, fill_r}));
   uvt_term uvt_term_i (.i_clk, .i_rst_n, .i_lclk, .i_lrst_n, .i_rx(rx), .i_server_signal_fail_in(ctl_r[3]),
      .i_tx_fs(1'b0), .o_tx(tx), .i_transmitted_trace_id(tx_id), .i_expected_trace_id(8'h5a),
      .i_trace_check_enable(ctl_r[2]), .i_monitoring_on(ctl_r[1]), .i_remote_defect_report_enable(ctl_r[0]),
      .o_accepted_trace_id(acc), .o_near_end_errored_block(neb), .o_far_end_errored_block(feb),
      .o_remote_defect_cause(rdc), .o_unequipped_defect(uneq), .o_trace_mismatch_defect(tim),
      .o_trail_signal_fail_action(tsf), .o_remote_defect_action(rda));
   // ====================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // expected {accepted id, uneq, tim, tsf, rda, rdc, transmitted rdi}
   function automatic logic [13:0] expv(input logic [13:0] c);
      logic tm;
      tm = c[2] && c[13:6] != 8'h5a;
      return {c[13:6], !c[5], tm, c[3] || tm, c[3] || tm, c[1] && !tm && c[4] && c[0], c[3] || tm};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic take(input logic [1:0] k, input logic [13:0] v);
      if (notes.size() == 0) chk("unexpected result", 16'hffff, {k, v});
      else chk("result", notes.pop_front(), {k, v});
   endtask
   task automatic frames(input int n);
      repeat (n) @(posedge rx.fs);
      @(posedge i_clk);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ====================
   // monitors: levels are compared once settled, since a step may move several in turn
   always @(posedge i_lclk) begin
      tcnt <= tx.fs ? 10'h001 : tcnt + 10'h001;
      if (tcnt == 10'h0ff && !tx.fs) tx_rdi <= tx.data[uvt_pkg::G1_RDI_POS];
   end
   initial begin
      wait (i_rst_n === 1'b1);
      forever begin
         @(posedge i_clk);
         if (neb === 1'b1 || feb === 1'b1) begin
            take({1'b0, feb === 1'b1}, 14'h0000);
         end else if (vec !== prev) begin
            repeat (3600) @(posedge i_clk);
            take(2'h2, {vec, tx_rdi});
            prev = vec;
         end
      end
   end
   initial begin
      #2000000;
      bad_count++;
      $display("watchdog expired");
      final_report;
   end
   // ====================
   // main sequence
   initial begin
      repeat (5) @(posedge i_lclk);
      i_lrst_n <= 1'b1;
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      notes.push_back('{2'h2, expv(ctl_r)});
      frames(4);
      for (int k = 0; k < 16; k++) begin
         rnd = xs(rnd);
         g1_r <= {k[3:0], 1'b0, rnd[2:0]};
         bad_r <= k[0];
         fill_r <= rnd[15:8];
         if (k[0]) notes.push_back('{2'h0, 14'h0000});
         if (k >= 1 && k <= 8) notes.push_back('{2'h1, 14'h0000});
         frames(1);
      end
      g1_r <= 8'h00;
      bad_r <= 1'b0;
      frames(3);
      chk("pulse notes left", 16'h0000, 16'(notes.size()));
      $display("test errored blocks done");
      for (int s = 1; s < 10; s++) begin
         frames(1);
         if (expv(STEPS[s]) != expv(ctl_r)) notes.push_back('{2'h2, expv(STEPS[s])});
         ctl_r <= STEPS[s];
         frames(5);
      end
      chk("status notes left", 16'h0000, 16'(notes.size()));
      $display("test status levels done");
      final_report;
   end
endmodule
`default_nettype wire

// ===== tb/uvt_far_end.sv
// uvt_far_end: far-side vc-3 source feeding the sink stream
// assumes i_cfg and i_bad stay stable over the last byte of each frame
`default_nettype none
module uvt_far_end (
   // link clock
   input  wire logic          i_lclk,
   input  wire logic          i_lrst_n,
   // frame config {j1, c2, g1, fill}
   input  wire logic [31:0]   i_cfg,
   input  wire logic          i_bad,
   // stream out
   output uvt_pkg::uvt_byte_s o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0]  cnt_r;
   logic [7:0]  acc_r;
   logic [7:0]  prv_r;
   logic [7:0]  b;
   logic [32:0] cfg_r;
   // ====================
   // byte map; fill varies per byte so parity sees real data
   always_comb begin
      case (cnt_r)
         10'h000: b = cfg_r[32:25];
         10'h055: b = prv_r ^ {7'h00, cfg_r[0]};
         10'h0aa: b = cfg_r[24:17];
         10'h0ff: b = cfg_r[16:9];
         default: b = cfg_r[8:1] ^ cnt_r[7:0];
      endcase
   end
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         cnt_r <= 10'h000;
         cfg_r <= {i_cfg, i_bad};
         prv_r <= 8'h00;
         acc_r <= 8'h00;
         o_rx  <= '0;
      end else begin
         cnt_r <= (cnt_r == 10'h2fc) ? 10'h000 : cnt_r + 10'h001;
         if (cnt_r == 10'h2fc) cfg_r <= {i_cfg, i_bad};
         if (cnt_r == 10'h000) prv_r <= acc_r;
         acc_r <= (cnt_r == 10'h000) ? b : acc_r ^ b;
         o_rx.data <= b;
         o_rx.fs <= (cnt_r == 10'h000);
      end
   end
endmodule
`default_nettype wire

// ===== tb/uvt_term_checker.sv
// uvt_term_checker: port-level properties of uvt_term
// assumes both resets are held long enough to clear the outputs
`default_nettype none
module uvt_term_checker (
   // clocks and resets
   input wire logic               i_clk,
   input wire logic               i_rst_n,
   input wire logic               i_lclk,
   input wire logic               i_lrst_n,
   // watched ports
   input wire logic               i_server_signal_fail_in,
   input wire logic [7:0]         i_transmitted_trace_id,
   input wire logic               i_monitoring_on,
   input wire uvt_pkg::uvt_byte_s o_tx,
   input wire logic               o_near_end_errored_block,
   input wire logic               o_far_end_errored_block,
   input wire logic               o_remote_defect_cause,
   input wire logic               o_trace_mismatch_defect,
   input wire logic               o_trail_signal_fail_action,
   input wire logic               o_remote_defect_action
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] cnt_r;
   logic [7:0] acc_r;
   logic [7:0] prv_r;
   logic [1:0] frm_r;
   wire logic  cause = i_server_signal_fail_in || o_trace_mismatch_defect;
   // ====================
   // tx frame tracking; b3 is judged only once a whole frame was seen
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) frm_r <= 2'h0;
      else if (o_tx.fs && frm_r != 2'h2) frm_r <= frm_r + 2'h1;
   end
   always_ff @(posedge i_lclk) begin
      cnt_r <= o_tx.fs ? 10'h001 : cnt_r + 10'h001;
      acc_r <= o_tx.fs ? o_tx.data : acc_r ^ o_tx.data;
      if (o_tx.fs) prv_r <= acc_r;
   end
   // ====================
   // transmit stream
   property p_j1;
      @(posedge i_lclk) disable iff (!i_lrst_n) o_tx.fs |-> o_tx.data == i_transmitted_trace_id;
   endproperty
   a_j1: assert property (p_j1) else $error("j1 wrong");
   property p_b3;
      @(posedge i_lclk) disable iff (!i_lrst_n)
         frm_r == 2'h2 && !o_tx.fs && cnt_r == 10'h055 |-> o_tx.data == prv_r;
   endproperty
   a_b3: assert property (p_b3) else $error("b3 wrong");
   property p_c2;
      @(posedge i_lclk) disable iff (!i_lrst_n) frm_r != 2'h0 && cnt_r == 10'h0aa |-> o_tx.data == 8'h00;
   endproperty
   a_c2: assert property (p_c2) else $error("c2 wrong");
   property p_g1;
      @(posedge i_lclk) disable iff (!i_lrst_n) frm_r != 2'h0 && cnt_r == 10'h0ff
         |-> o_tx.data[7:4] <= 4'h8 && o_tx.data[2:1] inside {2'h0, 2'h3};
   endproperty
   a_g1: assert property (p_g1) else $error("g1 wrong");
   property p_n1;
      @(posedge i_lclk) disable iff (!i_lrst_n) frm_r != 2'h0 && cnt_r == 10'h253 |-> o_tx.data == 8'h00;
   endproperty
   a_n1: assert property (p_n1) else $error("n1 wrong");
   property p_len;
      @(posedge i_lclk) disable iff (!i_lrst_n) frm_r != 2'h0 |-> o_tx.fs == (cnt_r == 10'h2fd);
   endproperty
   a_len: assert property (p_len) else $error("frame length wrong");
   // ====================
   // sink status
   property p_act_on;
      @(posedge i_clk) disable iff (!i_rst_n) cause [*8] |-> o_trail_signal_fail_action && o_remote_defect_action;
   endproperty
   a_act_on: assert property (p_act_on) else $error("fail actions missing");
   property p_act_off;
      @(posedge i_clk) disable iff (!i_rst_n)
         !cause [*8] |-> !o_trail_signal_fail_action && !o_remote_defect_action;
   endproperty
   a_act_off: assert property (p_act_off) else $error("fail actions without cause");
   property p_rdc;
      @(posedge i_clk) disable iff (!i_rst_n)
         (!i_monitoring_on || o_trace_mismatch_defect) [*8] |-> !o_remote_defect_cause;
   endproperty
   a_rdc: assert property (p_rdc) else $error("remote defect cause not gated");
   property p_neb;
      @(posedge i_clk) disable iff (!i_rst_n) o_near_end_errored_block |=> !o_near_end_errored_block [*8];
   endproperty
   a_neb: assert property (p_neb) else $error("near-end pulse too long");
   property p_feb;
      @(posedge i_clk) disable iff (!i_rst_n)
         o_far_end_errored_block |-> !o_near_end_errored_block ##1 !o_far_end_errored_block [*8];
   endproperty
   a_feb: assert property (p_feb) else $error("far-end pulse too long");
   c_neb: cover property (@(posedge i_clk) o_near_end_errored_block);
   c_feb: cover property (@(posedge i_clk) o_far_end_errored_block);
   c_tsf: cover property (@(posedge i_clk) $rose(o_trail_signal_fail_action));
endmodule
bind uvt_term uvt_term_checker uvt_term_checker_i (.i_clk, .i_rst_n, .i_lclk, .i_lrst_n,
   .i_server_signal_fail_in, .i_transmitted_trace_id, .i_monitoring_on, .o_tx, .o_near_end_errored_block,
   .o_far_end_errored_block, .o_remote_defect_cause, .o_trace_mismatch_defect, .o_trail_signal_fail_action,
   .o_remote_defect_action);
`default_nettype wire
